// >>> core/reset_park_test_strap_ctrl.sv
module reset_park_test_strap_ctrl #(
    parameter int STRAP_PINS = reset_park_pkg::STRAP_PINS
) (
    // clock and power-on reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // companion chip controls
    input wire logic fast_park_n_i,
    input wire logic factory_test_enable_i,
    input wire logic scan_port_reset_n_i,
    // test strap pins
    input wire logic [STRAP_PINS-1:0] test_strap_pin_i,
    output logic [STRAP_PINS-1:0] test_strap_pin_o,
    output logic [STRAP_PINS-1:0] test_strap_pin_oe_o,
    // trigger from the pattern engine
    input wire logic trigger_output_one_i,
    // status toward the rest of the controller
    output logic config_start_o,
    output logic config_active_o,
    output logic running_o,
    output logic test_mode_o,
    output logic [STRAP_PINS-1:0] strap_value_o,
    output logic park_request_o,
    output logic park_done_o
);
    // reset release synchroniser
    logic rst_meta;
    logic rst_sync_n;
    // pin synchronisers
    logic [STRAP_PINS-1:0] strap_meta;
    logic [STRAP_PINS-1:0] strap_sync;
    logic [1:0] park_meta;
    logic park_sync_n;
    logic [1:0] trig_pipe;
    // sequencer state and counters
    reset_park_pkg::seq_state_e state;
    reset_park_pkg::seq_state_e next_state;
    logic [7:0] delay_cnt;
    logic [4:0] park_cnt;
    logic cfg_done;
    // handshake to the strap latch
    strap_if #(.WIDTH(STRAP_PINS)) st ();

    // reset released through two flops, asserted at once
    // a synchronous release keeps flops from leaving reset on skewed edges
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // strap levels through two flops
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strap_meta <= reset_park_pkg::STRAP_RST;
            strap_sync <= reset_park_pkg::STRAP_RST;
        end else begin
            strap_meta <= test_strap_pin_i;
            strap_sync <= strap_meta;
        end
    end

    // fast park level through two flops, idle high
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            park_meta <= 2'h3;
        end else begin
            park_meta <= {park_meta[0], fast_park_n_i};
        end
    end
    // second flop only: low while the supervisor asks for a park
    assign park_sync_n = park_meta[1];

    // pins for the latch, strobes from the sequencer
    assign st.pins = strap_sync;
    assign st.clear = (state == reset_park_pkg::ST_RESET);
    assign st.sample = (state == reset_park_pkg::ST_WAIT) &&
        (delay_cnt == 8'(reset_park_pkg::STRAP_DELAY_CYC - 1));

    strap_latch #(.WIDTH(STRAP_PINS)) u_latch (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_sync_n),
        .st(st)
    );

    // sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            // one cycle here after release, then start waiting
            reset_park_pkg::ST_RESET: begin
                next_state = reset_park_pkg::ST_WAIT;
            end
            // wait for the strap sample strobe
            reset_park_pkg::ST_WAIT: begin
                if (st.sample) begin
                    next_state = reset_park_pkg::ST_CONFIG;
                end
            end
            // configuration ends once the sample is held
            reset_park_pkg::ST_CONFIG: begin
                if (cfg_done) begin
                    next_state = reset_park_pkg::ST_RUN;
                end
            end
            // stay running until the next reset
            reset_park_pkg::ST_RUN: begin
                next_state = reset_park_pkg::ST_RUN;
            end
            // illegal code: restart from the reset state
            default: begin
                next_state = reset_park_pkg::ST_RESET;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= reset_park_pkg::ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // counts cycles from release to the strap sample
    // cleared outside waiting, so a fresh reset always restarts it
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            delay_cnt <= 8'h00;
        end else if (state == reset_park_pkg::ST_WAIT) begin
            delay_cnt <= delay_cnt + 8'h01;
        end else begin
            delay_cnt <= 8'h00;
        end
    end

    // configuration takes one cycle after the sample lands
    assign cfg_done = st.held;

    // strap pins: undriven in reset and before the sample
    // the board pulls decide the sample while the pins are undriven
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            test_strap_pin_oe_o <= reset_park_pkg::STRAP_OE_RST;
            test_strap_pin_o <= reset_park_pkg::STRAP_RST;
        end else if (st.held) begin
            // from the sample on every strap pin is driven
            test_strap_pin_oe_o <= '1;
            test_strap_pin_o <= reset_park_pkg::STRAP_RST;
            test_strap_pin_o[reset_park_pkg::TRIG_PIN] <=
                trig_pipe[1];
        end
    end

    // trigger delayed to line up with the pin driver
    // gated by running so nothing reaches pin four during start-up
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trig_pipe <= 2'h0;
        end else begin
            trig_pipe <= {trig_pipe[0], trigger_output_one_i && running_o};
        end
    end

    // status outputs, all inactive in reset
    // each status bit is a flop of its own, so none can glitch
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            config_start_o <= 1'b0;
            config_active_o <= 1'b0;
            running_o <= 1'b0;
            test_mode_o <= 1'b0;
            strap_value_o <= reset_park_pkg::STRAP_RST;
        end else begin
            config_start_o <= (state == reset_park_pkg::ST_RESET);
            config_active_o <= (state != reset_park_pkg::ST_RUN);
            running_o <= (state == reset_park_pkg::ST_RUN);
            test_mode_o <= |st.value;
            strap_value_o <= st.value;
        end
    end

    // fast park: request while low, done after a fixed hold
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            park_request_o <= 1'b0;
            park_done_o <= 1'b0;
            park_cnt <= 5'h00;
        end else if (!park_sync_n) begin
            park_request_o <= 1'b1;
            // count the hold, then stay at the last count
            if (park_cnt == 5'(reset_park_pkg::PARK_CYC)) begin
                park_done_o <= 1'b1;
            end else begin
                park_cnt <= park_cnt + 5'h01;
            end
        end else begin
            // request gone: clear both and restart the count
            park_request_o <= 1'b0;
            park_done_o <= 1'b0;
            park_cnt <= 5'h00;
        end
    end
endmodule

// >>> shared/reset_park_pkg.sv
package reset_park_pkg;
    // system clock rate and period
    localparam int CLK_HZ = 40000000;
    localparam int CLK_PERIOD_NS = 25;
    // strap sampling delay after reset release, in nanoseconds
    localparam int STRAP_DELAY_NS = 1500;
    // sampling delay in clock cycles, at least one
    localparam int STRAP_DELAY_CYC =
        (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // number of test strap pins
    localparam int STRAP_PINS = 8;
    // strap pin that becomes the first trigger output
    localparam int TRIG_PIN = 4;
    // fast park request hold, in cycles, before park done is reported
    localparam int PARK_CYC = 16;
    // reset values
    localparam logic [7:0] STRAP_RST = 8'h00;
    localparam logic [7:0] STRAP_OE_RST = 8'h00;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_RESET  = 4'h1,
        ST_WAIT   = 4'h2,
        ST_CONFIG = 4'h4,
        ST_RUN    = 4'h8
    } seq_state_e;
endpackage

// >>> shared/strap_if.sv
// strap sample handshake between the sequencer and the strap latch
interface strap_if #(parameter int WIDTH = 8);
    logic sample;            // one-cycle sample strobe
    logic clear;             // drops the latched value
    logic [WIDTH-1:0] pins;  // synchronised strap levels
    logic [WIDTH-1:0] value; // latched test-mode selection
    logic held;              // a sample has been taken
    modport ctrl (output sample, output clear, output pins,
                  input value, input held);
    modport latch (input sample, input clear, input pins,
                   output value, output held);
endinterface

// >>> core/strap_latch.sv
// holds the strap sample taken once per reset release
module strap_latch #(
    parameter int WIDTH = 8
) (
    // clock and synchronised reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // sequencer side
    strap_if.latch st
);
    // capture once, keep until the next reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.value <= reset_park_pkg::STRAP_RST;
            st.held <= 1'b0;
        end else if (st.clear) begin
            st.value <= reset_park_pkg::STRAP_RST;
            st.held <= 1'b0;
        end else if (st.sample && !st.held) begin
            st.value <= st.pins;
            st.held <= 1'b1;
        end
    end
endmodule

// >>> test/rpt_chk.sv
module rpt_chk #(parameter int STRAP_PINS = 8) (
    // clock, reset and controls
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic fast_park_n_i,
    input wire logic trigger_output_one_i,
    input wire logic [STRAP_PINS-1:0] test_strap_pin_i,
    // watched outputs
    input wire logic [STRAP_PINS-1:0] test_strap_pin_o,
    input wire logic [STRAP_PINS-1:0] test_strap_pin_oe_o,
    input wire logic config_start_o,
    input wire logic config_active_o,
    input wire logic running_o,
    input wire logic test_mode_o,
    input wire logic [STRAP_PINS-1:0] strap_value_o,
    input wire logic park_request_o,
    input wire logic park_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain for every check
    default clocking @(posedge clk_sys_i); endclocking
    // no disable here: this one looks inside reset
    idle_reset_a: assert property (
        !rst_n_i |-> !(running_o | park_request_o | park_done_o
        | test_mode_o | |strap_value_o | |test_strap_pin_oe_o
        | |test_strap_pin_o | config_start_o | config_active_o))
        else $error("outputs active in reset");
    sample_time_a: assert property (disable iff (!rst_n_i)
        $rose(rst_n_i) |-> ##58 !test_strap_pin_oe_o
        ##[1:10] &test_strap_pin_oe_o) else $error("sample time off");
    drive_out_a: assert property (disable iff (!rst_n_i)
        running_o |-> &test_strap_pin_oe_o) else $error("straps undriven");
    test_mode_a: assert property (disable iff (!rst_n_i)
        running_o |-> test_mode_o == |strap_value_o)
        else $error("test mode wrong");
    strap_capture_a: assert property (disable iff (!rst_n_i)
        $rose(&test_strap_pin_oe_o) |->
        strap_value_o == $past(test_strap_pin_i, 4))
        else $error("strap sample wrong");
    strap_hold_a: assert property (disable iff (!rst_n_i)
        running_o && $past(running_o) |-> $stable(strap_value_o))
        else $error("strap value moved");
    trig_out_a: assert property (disable iff (!rst_n_i)
        running_o && $rose(trigger_output_one_i) |-> ##[2:4]
        test_strap_pin_o[4]) else $error("trigger not on pin four");
    park_req_a: assert property (disable iff (!rst_n_i)
        $fell(fast_park_n_i) |-> ##[2:4] park_request_o)
        else $error("park not requested");
    park_done_a: assert property (disable iff (!rst_n_i)
        $rose(park_request_o) |-> (!park_done_o)[*8] ##[8:10] park_done_o)
        else $error("park done timing");
endmodule
bind reset_park_test_strap_ctrl rpt_chk #(
    .STRAP_PINS(STRAP_PINS)
) chk_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .fast_park_n_i(fast_park_n_i),
    .trigger_output_one_i(trigger_output_one_i),
    .test_strap_pin_i(test_strap_pin_i),
    .test_strap_pin_o(test_strap_pin_o),
    .test_strap_pin_oe_o(test_strap_pin_oe_o),
    .config_start_o(config_start_o),
    .config_active_o(config_active_o),
    .running_o(running_o),
    .test_mode_o(test_mode_o),
    .strap_value_o(strap_value_o),
    .park_request_o(park_request_o),
    .park_done_o(park_done_o)
);

// >>> test/power_supervisor.sv
// companion chip: drives reset and fast park, ties test inputs
module power_supervisor (
    // commands from the bench
    input wire logic clk_sys_i,
    input wire logic hold_i,
    input wire logic park_i,
    // pins toward the controller
    output logic rst_n_o,
    output logic fast_park_n_o,
    output logic factory_test_enable_o,
    output logic scan_port_reset_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // power up in reset, park idle
    initial begin
        fast_park_n_o = 1'b1;
        // reset falls after time zero so every flop sees the edge
        #1;
        rst_n_o = 1'b0;
    end
    // reset lifted only once supplies are declared stable
    always @(negedge clk_sys_i) begin
        rst_n_o <= !hold_i;
        fast_park_n_o <= !park_i;
    end
    // test inputs kept low for normal operation
    assign factory_test_enable_o = 1'b0;
    assign scan_port_reset_n_o = 1'b0;
endmodule

// >>> test/test_reset_park_test_strap_ctrl.sv
module test_reset_park_test_strap_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic hold = 1'b1; // supervisor holds reset
    logic park = 1'b0; // fast park command
    logic trig = 1'b0; // pattern engine trigger
    logic [7:0] ext = 8'h00; // board pull levels, pulldown by default
    logic rst_n, park_n, fte, sprn, cfg_start, run, tmode, preq, pdone, cact;
    logic [7:0] pin_o, pin_oe, pin_w, sv;
    int failures = 0;
    int comparisons = 0;
    // 40 MHz clock
    always #12.5 clk_sys_i = ~clk_sys_i;
    // pin level: block drive when enabled, else board pull
    assign pin_w = (pin_oe & pin_o) | (~pin_oe & ext);
    power_supervisor sup (.clk_sys_i(clk_sys_i), .hold_i(hold),
        .park_i(park), .rst_n_o(rst_n), .fast_park_n_o(park_n),
        .factory_test_enable_o(fte), .scan_port_reset_n_o(sprn));
    reset_park_test_strap_ctrl uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n),
        .fast_park_n_i(park_n), .factory_test_enable_i(fte),
        .scan_port_reset_n_i(sprn), .test_strap_pin_i(pin_w),
        .test_strap_pin_o(pin_o), .test_strap_pin_oe_o(pin_oe),
        .trigger_output_one_i(trig), .config_start_o(cfg_start),
        .config_active_o(cact), .running_o(run), .test_mode_o(tmode),
        .strap_value_o(sv), .park_request_o(preq), .park_done_o(pdone));
    // compare and count
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // reset with given straps, boot, check the sample
    task boot(input logic [7:0] s);
        int i;
        ext <= s;
        hold <= 1'b1;
        cyc(4);
        chk({3'h0, run, cfg_start, tmode, preq, pdone}, 8'h00);
        chk({7'h00, cact}, 8'h00);
        chk(pin_o | sv, 8'h00);
        chk(pin_oe, 8'h00);
        hold <= 1'b0;
        for (i = 0; i < 9 && cfg_start !== 1'b1; i++) cyc(1);
        chk({7'h00, cfg_start}, 8'h01);
        chk({7'h00, cact}, 8'h01);
        for (i = 0; i < 200 && run !== 1'b1; i++) cyc(1);
        chk(8'(i), 8'(reset_park_pkg::STRAP_DELAY_CYC + 2));
        chk({7'h00, cact}, 8'h00);
        chk(sv, s);
        chk({7'h00, tmode}, {7'h00, |s});
        chk(pin_oe, 8'hff);
        ext <= ~s;
        cyc(10);
        chk(sv, s);
    endtask
    // trigger reaches pin four only
    task trigger;
        trig <= 1'b1;
        cyc(5);
        chk(pin_w, 8'h10);
        trig <= 1'b0;
        cyc(5);
        chk(pin_w, 8'h00);
    endtask
    // fast park request, completion and release
    task park_test;
        park <= 1'b1;
        cyc(6);
        chk({6'h00, preq, pdone}, 8'h02);
        cyc(19);
        chk({6'h00, preq, pdone}, 8'h03);
        park <= 1'b0;
        cyc(6);
        chk({6'h00, preq, pdone}, 8'h00);
    endtask
    // verdict
    task finish_test;
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence, later boots reset in mid-run
    initial begin
        cyc(1);
        boot(8'h00);
        trigger;
        park_test;
        boot(8'h91);
        trigger;
        boot(8'h10);
        finish_test;
    end
    // watchdog
    initial begin
        #100us;
        failures++;
        finish_test;
    end
endmodule
